// ===== logic/periodic_timer.sv
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
module periodic_timer
  import ptimer_pkg::*;
(
  input wire logic pclk, // Bus and timer clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic ext_trig, // External trigger pin, edge starts single pulse
  output logic tm_out, // Timer output pin level
  output logic tm_out_oe_n // Low while the pin is driven
);

  tmr_state_t st;
  tmr_state_t nx;
  logic tick;
  logic [10:0] cnt_inc;
  logic [10:0] per;
  logic m_a;
  logic m_p;
  logic sp;
  logic run_rise;
  logic pwm_act;
  logic lvl;
  logic wr;

  function automatic logic known(input logic [7:0] a);
    known = (a[1:0] == 2'h0) && (a <= OFF_STATUS);
  endfunction

  function automatic logic [5:0] pre_mask(input logic [1:0] s);
    case (s)
      2'h0: pre_mask = 6'h00;
      2'h1: pre_mask = 6'h03;
      2'h2: pre_mask = 6'h0F;
      default: pre_mask = 6'h3F;
    endcase
  endfunction

  function automatic logic [31:0] rd_mux(input tmr_state_t s,
                                         input logic [7:0] a);
    case (a)
      OFF_CTRL0: rd_mux = {29'h0, s.clk_sel, s.run};
      OFF_CTRL1: rd_mux = {24'h0, s.mode, s.pa, s.oc, s.inv, 1'b0,
                           s.clr_sel};
      OFF_CNT_LO: rd_mux = {24'h0, s.cnt[7:0]};
      OFF_CNT_HI: rd_mux = {30'h0, s.cnt[9:8]};
      OFF_CMPA_LO: rd_mux = {24'h0, s.compare_a_value[7:0]};
      OFF_CMPA_HI: rd_mux = {30'h0, s.compare_a_value[9:8]};
      OFF_PER_LO: rd_mux = {24'h0, s.period_compare_value[7:0]};
      OFF_PER_HI: rd_mux = {30'h0, s.period_compare_value[9:8]};
      OFF_STATUS: rd_mux = {30'h0, s.flag_p, s.flag_a};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !known(paddr);
  assign tm_out = st.out;
  assign tm_out_oe_n = st.oe_n;
  assign wr = psel && penable && pwrite && known(paddr);

  always_comb begin
    nx = st;
    tick = (st.pre & pre_mask(st.clk_sel)) == pre_mask(st.clk_sel);
    nx.pre = st.pre + 6'h01;
    cnt_inc = {1'b0, st.cnt} + 11'h001;
    per = (st.period_compare_value == VAL_RESET) ? FULL_PERIOD : {1'b0, st.period_compare_value};
    run_rise = st.run && !st.run_d;
    sp = (st.mode == MODE_PWM) && (st.pa == PA_PULSE);
    m_a = st.run && tick && !run_rise && (st.compare_a_value != VAL_RESET)
          && (cnt_inc == {1'b0, st.compare_a_value});
    m_p = st.run && tick && !run_rise && (cnt_inc == per);
    nx.run_d = st.run;
    nx.trig_d = ext_trig;
    if (psel && !penable && !pwrite) begin
      nx.rdata = rd_mux(st, paddr);
    end
    if (wr) begin
      case (paddr)
        OFF_CTRL0: begin
          nx.run = pwdata[0];
          nx.clk_sel = pwdata[2:1];
        end
        OFF_CTRL1: begin
          nx.mode = pwdata[7:6];
          nx.pa = pwdata[5:4];
          nx.oc = pwdata[3];
          nx.inv = pwdata[2];
          nx.clr_sel = pwdata[0];
        end
        OFF_CMPA_LO: nx.compare_a_value[7:0] = pwdata[7:0];
        OFF_CMPA_HI: nx.compare_a_value[9:8] = pwdata[1:0];
        OFF_PER_LO: nx.period_compare_value[7:0] = pwdata[7:0];
        OFF_PER_HI: nx.period_compare_value[9:8] = pwdata[1:0];
        OFF_STATUS: begin
          if (pwdata[0]) begin
            nx.flag_a = 1'b0;
          end
          if (pwdata[1]) begin
            nx.flag_p = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (sp && ext_trig && !st.trig_d) begin
      nx.run = 1'b1;
    end
    if (run_rise) begin
      nx.cnt = CNT_RESET;
      nx.pin_lvl = st.oc;
    end else if (st.run && tick) begin
      if (sp) begin
        // no clear on period in single pulse
        nx.cnt = cnt_inc[9:0];
        if (m_a) begin
          nx.run = 1'b0;
          nx.flag_a = 1'b1;
        end
      end else if (st.mode == MODE_PWM) begin
        // both flags, clear select ignored
        // Built on nx so a same-cycle clear lands; set still wins
        nx.cnt = m_p ? CNT_RESET : cnt_inc[9:0];
        nx.flag_a = nx.flag_a || m_a;
        nx.flag_p = nx.flag_p || m_p;
      end else if (st.clr_sel) begin
        // clear on A, no P flag
        nx.cnt = m_a ? CNT_RESET : cnt_inc[9:0];
        nx.flag_a = nx.flag_a || m_a;
      end else begin
        nx.cnt = m_p ? CNT_RESET : cnt_inc[9:0];
        nx.flag_a = nx.flag_a || m_a;
        nx.flag_p = nx.flag_p || m_p;
      end
      // only A match moves the pin
      if (m_a && (st.mode == MODE_CMP)) begin
        case (st.pa)
          PA_LOW: nx.pin_lvl = 1'b0;
          PA_HIGH: nx.pin_lvl = 1'b1;
          PA_TOGGLE: nx.pin_lvl = !st.pin_lvl;
          default: nx.pin_lvl = st.pin_lvl;
        endcase
      end
    end
    // duty at or over period is full
    pwm_act = ({1'b0, st.cnt} < {1'b0, st.compare_a_value})
              || ({1'b0, st.compare_a_value} >= per);
    case (st.mode)
      MODE_CMP: lvl = st.pin_lvl;
      MODE_PWM: begin
        if (sp) begin
          lvl = st.run ? st.oc : !st.oc;
        end else if (st.pa == PA_NONE) begin
          lvl = 1'b0;
        end else if (st.pa == PA_LOW) begin
          lvl = 1'b1;
        end else begin
          lvl = pwm_act ? st.oc : !st.oc;
        end
      end
      default: lvl = 1'b0;
    endcase
    nx.oe_n = !((st.mode == MODE_CMP) || (st.mode == MODE_PWM));
    nx.out = nx.oe_n ? 1'b0 : (lvl ^ st.inv);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.oe_n <= 1'b1;
      st.cnt <= CNT_RESET;
      st.pre <= PRE_RESET;
      st.compare_a_value <= VAL_RESET;
      st.period_compare_value <= VAL_RESET;
    end else begin
      st <= nx;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sp_match;
    sp && st.run && tick && !run_rise && (st.compare_a_value != VAL_RESET)
    && (cnt_inc == {1'b0, st.compare_a_value});
  endsequence

  property p_per_hi_zero;
    psel && !penable && !pwrite && (paddr == OFF_PER_HI)
    |=> st.rdata[31:2] == 30'h0;
  endproperty
  a_per_hi_zero: assert property (p_per_hi_zero)
    else $error("period high byte upper bits not zero");

  property p_per_lo_wr;
    wr && (paddr == OFF_PER_LO) |=> st.period_compare_value[7:0] == $past(pwdata[7:0]);
  endproperty
  a_per_lo_wr: assert property (p_per_lo_wr)
    else $error("period low byte not stored");

  property p_init_lvl;
    run_rise |=> st.pin_lvl == $past(st.oc) && st.cnt == CNT_RESET;
  endproperty
  a_init_lvl: assert property (p_init_lvl)
    else $error("run rise did not load initial level");

  property p_no_pflag;
    $rose(st.flag_p) |-> $past(!st.clr_sel || st.mode == MODE_PWM);
  endproperty
  a_no_pflag: assert property (p_no_pflag)
    else $error("P flag raised with A clear select");

  property p_zero_a;
    $rose(st.flag_a) |-> $past(st.compare_a_value) != VAL_RESET;
  endproperty
  a_zero_a: assert property (p_zero_a)
    else $error("A flag raised with zero compare value");

  property p_tmr_free;
    st.mode == MODE_TMR |=> tm_out_oe_n && !tm_out;
  endproperty
  a_tmr_free: assert property (p_tmr_free)
    else $error("timer mode drove the pin");

  property p_full_duty;
    (st.mode == MODE_PWM) && (st.pa == PA_PWM) && st.oc && !st.inv
    && ({1'b0, st.compare_a_value} >= per) |=> tm_out;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty output went inactive");

  property p_sp_end;
    s_sp_match |=> !st.run && st.flag_a;
  endproperty
  a_sp_end: assert property (p_sp_end)
    else $error("single pulse match did not end pulse");

  property p_clr_p;
    (st.mode == MODE_CMP) && !st.clr_sel && m_p |=> st.cnt == CNT_RESET;
  endproperty
  a_clr_p: assert property (p_clr_p)
    else $error("period match did not clear counter");

  // Compare-mode A match, shared by the pin action checks
  sequence s_cmp_match;
    (st.mode == MODE_CMP) && m_a;
  endsequence

  property p_pa_set;
    s_cmp_match ##0 (st.pa == PA_HIGH) |=> st.pin_lvl;
  endproperty
  a_pa_set: assert property (p_pa_set)
    else $error("pin action high did not set pin");

  property p_pa_clear;
    s_cmp_match ##0 (st.pa == PA_LOW) |=> !st.pin_lvl;
  endproperty
  a_pa_clear: assert property (p_pa_clear)
    else $error("pin action low did not clear pin");

  property p_pa_toggle;
    s_cmp_match ##0 (st.pa == PA_TOGGLE)
    |=> st.pin_lvl != $past(st.pin_lvl);
  endproperty
  a_pa_toggle: assert property (p_pa_toggle)
    else $error("pin action toggle did not toggle pin");

  property p_pa_hold;
    s_cmp_match ##0 (st.pa == PA_NONE)
    |=> st.pin_lvl == $past(st.pin_lvl);
  endproperty
  a_pa_hold: assert property (p_pa_hold)
    else $error("pin action zero moved the pin");

  property p_p_no_pin;
    (st.mode == MODE_CMP) && m_p && !m_a
    |=> st.pin_lvl == $past(st.pin_lvl);
  endproperty
  a_p_no_pin: assert property (p_p_no_pin)
    else $error("period match moved the compare pin");

  property p_clr_a;
    (st.mode == MODE_CMP) && st.clr_sel && m_a |=> st.cnt == CNT_RESET;
  endproperty
  a_clr_a: assert property (p_clr_a)
    else $error("compare A match did not clear counter");

  property p_stop_hold;
    !st.run |=> st.cnt == $past(st.cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter moved while stopped");

  property p_pwm_clr;
    (st.mode == MODE_PWM) && !sp && m_p |=> st.cnt == CNT_RESET;
  endproperty
  a_pwm_clr: assert property (p_pwm_clr)
    else $error("PWM period match did not clear counter");

  property p_pwm_flag_a;
    (st.mode == MODE_PWM) && !sp && m_a |=> st.flag_a;
  endproperty
  a_pwm_flag_a: assert property (p_pwm_flag_a)
    else $error("PWM A match did not raise A flag");

  property p_pwm_flag_p;
    (st.mode == MODE_PWM) && !sp && m_p |=> st.flag_p;
  endproperty
  a_pwm_flag_p: assert property (p_pwm_flag_p)
    else $error("PWM P match did not raise P flag");

  property p_forced_low;
    (st.mode == MODE_PWM) && (st.pa == PA_NONE)
    |=> tm_out == $past(st.inv);
  endproperty
  a_forced_low: assert property (p_forced_low)
    else $error("PWM forced low level wrong");

  // Trigger edge in single pulse, no match that cycle
  sequence s_trig_edge;
    sp && ext_trig && !st.trig_d && !m_a;
  endsequence

  property p_trig_run;
    s_trig_edge |=> st.run;
  endproperty
  a_trig_run: assert property (p_trig_run)
    else $error("trigger edge did not set run");

  property p_sp_count;
    sp && st.run && tick && !run_rise
    |=> st.cnt == $past(st.cnt) + 10'h001;
  endproperty
  a_sp_count: assert property (p_sp_count)
    else $error("single pulse counter did not advance");

endmodule // periodic_timer

// ===== logic/ptimer_pkg.sv
// Function
// - Period value is 10 bits, low byte plus bits 1:0 of high byte.
// - Period high byte bits 7 to 2 always read as zero.
// - Two-bit mode field selects compare, capture, PWM, timer; single pulse is PWM with pin action 11.
// - Compare mode, clear select low: clear on P match or overflow, both flags.
// - Clear select high: clear on A match, only the A flag raised.
// - Compare-A value zero: count to 3FF and overflow, no A flag.
// - Compare mode pin changes only on A match, never on P match.
// - Pin action field sets, clears or toggles pin on A match; zero holds.
// - Run bit rising edge loads pin with the initial level bit.
// - Timer mode counts and flags like compare mode but leaves pin undriven.
// - PWM mode clears on period match; period zero gives 1024 counts.
// - PWM ignores clear select; flags for every A and P match.
// - Duty at or above period keeps PWM output active whole period.
// - PWM polarity from initial level bit, invert bit, pin action forcing.
// - PWM counting continues with pin action 00 or 01.
// - Run rising starts single pulse; trigger pin edge sets run bit.
// - Pulse ends on run cleared or A match; match clears run, flags.
// - Single pulse counter zeroed only on run rise; period unused.
package ptimer_pkg;
  localparam logic [7:0] OFF_CTRL0 = 8'h00;
  localparam logic [7:0] OFF_CTRL1 = 8'h04;
  localparam logic [7:0] OFF_CNT_LO = 8'h08;
  localparam logic [7:0] OFF_CNT_HI = 8'h0C;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_PER_LO = 8'h18;
  localparam logic [7:0] OFF_PER_HI = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAPT = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  localparam logic [1:0] PA_NONE = 2'h0;
  localparam logic [1:0] PA_LOW = 2'h1;
  localparam logic [1:0] PA_HIGH = 2'h2;
  localparam logic [1:0] PA_TOGGLE = 2'h3;
  localparam logic [1:0] PA_PWM = 2'h2;
  localparam logic [1:0] PA_PULSE = 2'h3;
  localparam logic [9:0] CNT_RESET = 10'h000;
  localparam logic [9:0] VAL_RESET = 10'h000;
  localparam logic [10:0] FULL_PERIOD = 11'h400;
  localparam logic [5:0] PRE_RESET = 6'h00;

  typedef struct packed {
    logic run;
    logic run_d;
    logic trig_d;
    logic [1:0] clk_sel;
    logic [1:0] mode;
    logic [1:0] pa;
    logic oc;
    logic inv;
    logic clr_sel;
    logic [9:0] compare_a_value;
    logic [9:0] period_compare_value;
    logic [9:0] cnt;
    logic [5:0] pre;
    logic flag_a;
    logic flag_p;
    logic pin_lvl;
    logic out;
    logic oe_n;
    logic [31:0] rdata;
  } tmr_state_t;
endpackage

// ===== bench/tb_periodic_timer.sv
`timescale 1ns/1ps
module tb_periodic_timer;
  import ptimer_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, ext_trig;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic pready, pslverr, tm_out, tm_out_oe_n, e;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int k;

  periodic_timer periodic_timer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_trig(ext_trig),
    .tm_out(tm_out), .tm_out_oe_n(tm_out_oe_n)
  );

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Ceiling well above the longest test
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s exp %h got %h", what, exp, got);
    end
  endtask

  // Setup, then access held until pready is seen high
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(string what, logic [7:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(what, exp, r);
  endtask

  task automatic setup(logic [7:0] c1, logic [7:0] per, logic [7:0] cmpa);
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_PER_LO, per);
    wr(OFF_PER_HI, 8'h00);
    wr(OFF_CMPA_LO, cmpa);
    wr(OFF_CMPA_HI, 8'h00);
    wr(OFF_CTRL1, c1);
    wr(OFF_STATUS, 8'h03);
  endtask

  // Pin level sampled once per cycle
  task automatic high_count(int n);
    k = 0;
    // Pin lags the state by one edge, skip the stale sample
    @(posedge pclk);
    repeat (n) begin
      @(posedge pclk);
      k += (tm_out === 1'b1);
    end
  endtask

  task automatic t_regs();
    rd("per_lo", OFF_PER_LO, 32'h00000000);
    rd("per_hi", OFF_PER_HI, 32'h00000000);
    wr(OFF_PER_HI, 8'hFF);
    rd("per_hi", OFF_PER_HI, 32'h00000003);
    wr(OFF_PER_LO, 8'hA5);
    rd("per_lo", OFF_PER_LO, 32'h000000A5);
    rd("unmapped", 8'h24, 32'h00000000);
    chk("slverr", 32'h00000001, {31'h0, e});
    ext_trig <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_trig <= 1'b0;
    rd("run ignored", OFF_CTRL0, 32'h00000000);
    $display("test regs done");
  endtask

  task automatic t_cmp();
    setup(8'h38, 8'd60, 8'd30);
    wr(OFF_CTRL0, 8'h01);
    repeat (4) @(posedge pclk);
    chk("init level", 32'h00000001, {31'h0, tm_out});
    chk("oe_n", 32'h00000000, {31'h0, tm_out_oe_n});
    repeat (36) @(posedge pclk);
    rd("status a", OFF_STATUS, 32'h00000001);
    chk("toggle", 32'h00000000, {31'h0, tm_out});
    repeat (25) @(posedge pclk);
    rd("status ap", OFF_STATUS, 32'h00000003);
    chk("p no pin", 32'h00000000, {31'h0, tm_out});
    repeat (25) @(posedge pclk);
    chk("toggle back", 32'h00000001, {31'h0, tm_out});
    wr(OFF_CTRL1, 8'h40);
    repeat (2) @(posedge pclk);
    chk("capt oe_n", 32'h00000001, {31'h0, tm_out_oe_n});
    $display("test compare done");
  endtask

  task automatic t_clr();
    setup(8'h01, 8'd10, 8'd40);
    wr(OFF_CTRL0, 8'h01);
    repeat (100) @(posedge pclk);
    rd("clr a", OFF_STATUS, 32'h00000001);
    setup(8'h01, 8'd10, 8'd0);
    wr(OFF_CTRL0, 8'h01);
    repeat (1100) @(posedge pclk);
    rd("zero a", OFF_STATUS, 32'h00000000);
    $display("test clear done");
  endtask

  task automatic t_tmr();
    setup(8'hC0, 8'd20, 8'd10);
    wr(OFF_CTRL0, 8'h01);
    repeat (50) @(posedge pclk);
    chk("tmr oe_n", 32'h00000001, {31'h0, tm_out_oe_n});
    chk("tmr pin", 32'h00000000, {31'h0, tm_out});
    rd("tmr flags", OFF_STATUS, 32'h00000003);
    $display("test timer done");
  endtask

  // Timer mode on pclk/4: forty edges give exactly ten ticks
  task automatic t_div();
    setup(8'hC0, 8'd0, 8'd5);
    wr(OFF_CTRL0, 8'h03);
    repeat (40) @(posedge pclk);
    rd("cnt lo", OFF_CNT_LO, 32'h0000000A);
    rd("cnt hi", OFF_CNT_HI, 32'h00000000);
    rd("div flag a", OFF_STATUS, 32'h00000001);
    wr(OFF_CTRL0, 8'h01);
    wr(OFF_STATUS, 8'h01);
    rd("flag cleared", OFF_STATUS, 32'h00000000);
    $display("test divider done");
  endtask

  task automatic t_pwm();
    // Clear select set on purpose, it must not matter
    setup(8'hA9, 8'd8, 8'd2);
    wr(OFF_CTRL0, 8'h01);
    repeat (10) @(posedge pclk);
    high_count(16);
    chk("duty", 32'd4, k);
    rd("pwm flags", OFF_STATUS, 32'h00000003);
    wr(OFF_CMPA_LO, 8'd8);
    high_count(16);
    chk("full duty", 32'd16, k);
    wr(OFF_CTRL1, 8'hAD);
    high_count(16);
    chk("inverted", 32'd0, k);
    wr(OFF_CTRL1, 8'h89);
    wr(OFF_STATUS, 8'h03);
    repeat (20) @(posedge pclk);
    high_count(16);
    chk("forced", 32'd0, k);
    rd("still run", OFF_STATUS, 32'h00000003);
    wr(OFF_CTRL1, 8'h99);
    high_count(16);
    chk("forced high", 32'd16, k);
    $display("test pwm done");
  endtask

  task automatic t_pulse();
    setup(8'hB8, 8'd8, 8'd10);
    ext_trig <= 1'b1;
    repeat (3) @(posedge pclk);
    ext_trig <= 1'b0;
    high_count(40);
    chk("width", 32'd1, {31'h0, k >= 8 && k <= 12});
    rd("run cleared", OFF_CTRL0, 32'h00000000);
    apb(1'b0, OFF_STATUS, 32'h00000000);
    chk("pulse flag", 32'h00000001, {31'h0, r[0]});
    chk("trailing", 32'h00000000, {31'h0, tm_out});
    $display("test pulse done");
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    ext_trig = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_cmp();
    t_clr();
    t_tmr();
    t_div();
    t_pwm();
    t_pulse();
    results();
  end
endmodule // tb_periodic_timer
